// File: cocr_host.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Host master byte writes and reads
// ****
module cocr_host (
    input wire logic clk,
    input wire logic [7:0] rd_data,
    output logic wr_en,
    output logic [7:0] wr_addr,
    output logic [7:0] wr_data,
    output logic rd_en,
    output logic [7:0] rd_addr
);
    initial {wr_en, wr_addr, wr_data, rd_en, rd_addr} = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        {wr_en, wr_addr, wr_data} = {1'b1, a, d};
        @(negedge clk);
        {wr_en, wr_data} = {1'b0, ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        {rd_en, rd_addr} = {1'b1, a};
        @(negedge clk);
        rd_en = 1'b0;
        d = rd_data;
    endtask
    task automatic cp_d1(input logic [7:0] v);
        wr(8'h55, v);
    endtask
    task automatic cp_d1_p3(input logic [7:0] v);
        wr(8'h55, v >> 2);
    endtask
    task automatic cp_d2(input logic [1:0] ds, input logic [5:0] s);
        wr(8'h57, {ds, s});
    endtask
endmodule
`default_nettype wire

// File: cocr_lock_timer.sv
`timescale 1ns/10ps
`default_nettype none
module cocr_lock_timer #(
    parameter int LOCK_CYC = 150
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic pll_on,
    input wire logic restart,
    output logic locked
);
    logic [15:0] count_reg;

    // ****************************************
    // Lock interval counter
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_reg <= 16'h0000;
            locked <= 1'b0;
        end else if (ce) begin
            if (!pll_on || restart) begin
                count_reg <= 16'h0000;
                locked <= 1'b0;
            end else if (count_reg == 16'(LOCK_CYC - 1)) begin
                locked <= 1'b1;
            end else begin
                count_reg <= count_reg + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// File: cocr_pkg.sv
// Function
// - Third output frequency from 13H,14H,15H,53H
// - 53H low bits drive second output strength
// - 55H selects first duplicate source
// - Bits 7:6 of 55H are ignored
// - 57H holds second duplicate source and strength
// - At power-on only second duplicate runs
// - Synthesized output valid after PLL lock time
// - Buffer enable and PLL power separately controlled
// - Off code in 53H leaves PLL powered; only 15H = 00 powers it down
// - Every strength field resets to 10
// - Strength codes ordered 00 weakest, 11 strongest
// - Strength fields in 54H, 56H, 57H
// - 48H bits 7:6 set first output strength
package cocr_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] ADDR_P1_SEL = 8'h48;
    localparam logic [7:0] ADDR_P2_SEL = 8'h50;
    localparam logic [7:0] ADDR_P3_DIV_LO = 8'h13;
    localparam logic [7:0] ADDR_P3_DIV_HI = 8'h14;
    localparam logic [7:0] ADDR_P3_PLL = 8'h15;
    localparam logic [7:0] ADDR_P3_SEL = 8'h53;
    localparam logic [7:0] ADDR_P3_DS = 8'h54;
    localparam logic [7:0] ADDR_D1_SRC = 8'h55;
    localparam logic [7:0] ADDR_D1_DS = 8'h56;
    localparam logic [7:0] ADDR_D2_CFG = 8'h57;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] RST_P1_SEL = 8'h8D;
    localparam logic [7:0] RST_P2_SEL = 8'h8E;
    localparam logic [7:0] RST_P3_DIV = 8'h00;
    localparam logic [7:0] RST_P3_PLL = 8'h00;
    localparam logic [7:0] RST_P3_SEL = 8'h3E;
    localparam logic [1:0] RST_DS = 2'h2;
    localparam logic [7:0] RST_D1_SRC = 8'h0C;
    localparam logic [5:0] RST_D2_SRC = 6'h18;
    // ****************************************
    // Source codes and fixed fields
    // ****************************************
    localparam logic [5:0] SRC_OFF = 6'h0C;
    localparam logic [5:0] SRC_REF = 6'h18;
    localparam logic [5:0] P3_SEL_OFF = 6'h0F;
    localparam logic [1:0] D1_DS_FIXED_HI = 2'h3;
    localparam int DS_LSB_P1 = 6;
    localparam int DS_LSB_P3 = 6;
    localparam int DS_LSB_D1 = 4;
    localparam int DS_LSB_D2 = 6;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_MHZ = 50;
    localparam int PLL_LOCK_US = 3;
    localparam int PLL_LOCK_CYC = PLL_LOCK_US * CLK_MHZ;
    typedef enum logic [1:0] {SRC_NONE, SRC_REFCLK, SRC_P1, SRC_P2} cocr_src_e;
    typedef enum logic [1:0] {SRC3_NONE, SRC3_P3} cocr_dummy_e;
endpackage

// File: cocr_regs.sv
`timescale 1ns/10ps
`default_nettype none
module cocr_regs
    import cocr_pkg::*;
#(
    parameter int LOCK_CYC = cocr_pkg::PLL_LOCK_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic rd_en,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data,
    output logic [1:0] p1_drive_strength_field,
    output logic [1:0] p2_drive_strength_field,
    output logic [1:0] p3_drive_strength_field,
    output logic [1:0] d1_drive_strength_field,
    output logic [1:0] d2_drive_strength_field,
    output logic [15:0] p3_divider,
    output logic [7:0] p3_pll_config,
    output logic [5:0] p3_freq_select,
    output logic p3_pll_power,
    output logic p3_pll_locked,
    output logic primary_out_three_enable,
    output logic [1:0] duplicate_out_one_source,
    output logic duplicate_out_one_enable,
    output logic [1:0] duplicate_out_two_source,
    output logic duplicate_out_two_enable
);
    import cocr_pkg::*;

    logic [7:0] p1_sel_reg;
    logic [7:0] p2_sel_reg;
    logic [7:0] p3_div_lo_reg;
    logic [7:0] p3_div_hi_reg;
    logic [7:0] p3_pll_reg;
    logic [7:0] p3_sel_reg;
    logic [1:0] p3_ds_reg;
    logic [7:0] d1_src_reg;
    logic [1:0] d1_ds_reg;
    logic [7:0] d2_cfg_reg;
    logic p3_restart;
    logic p3_lock_raw;

    // ****************************************
    // Source decode
    // ****************************************
    function automatic logic [2:0] src_decode(input logic [5:0] code);
        logic [2:0] r;
        r = 3'h0;
        if (code == SRC_OFF) begin
            r = 3'h0;
        end else if (code == SRC_REF) begin
            r = 3'h1;
        end else if (code == p1_sel_reg[5:0]) begin
            r = 3'h2;
        end else if (code == p2_sel_reg[5:0]) begin
            r = 3'h3;
        end else if (code == p3_sel_reg[7:2]) begin
            r = 3'h4;
        end
        return r;
    endfunction

    // ****************************************
    // Register writes
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            p1_sel_reg <= RST_P1_SEL;
            p2_sel_reg <= RST_P2_SEL;
            p3_div_lo_reg <= RST_P3_DIV;
            p3_div_hi_reg <= RST_P3_DIV;
            p3_pll_reg <= RST_P3_PLL;
            p3_sel_reg <= RST_P3_SEL;
            p3_ds_reg <= RST_DS;
            d1_src_reg <= RST_D1_SRC;
            d1_ds_reg <= RST_DS;
            d2_cfg_reg <= {RST_DS, RST_D2_SRC};
        end else if (ce && wr_en) begin
            unique case (wr_addr)
                ADDR_P1_SEL: p1_sel_reg <= wr_data;
                ADDR_P2_SEL: p2_sel_reg <= wr_data;
                ADDR_P3_DIV_LO: p3_div_lo_reg <= wr_data;
                ADDR_P3_DIV_HI: p3_div_hi_reg <= wr_data;
                ADDR_P3_PLL: p3_pll_reg <= wr_data;
                ADDR_P3_SEL: p3_sel_reg <= wr_data;
                ADDR_P3_DS: p3_ds_reg <= wr_data[DS_LSB_P3 +: 2];
                ADDR_D1_SRC: d1_src_reg <= wr_data;
                ADDR_D1_DS: d1_ds_reg <= wr_data[DS_LSB_D1 +: 2];
                ADDR_D2_CFG: d2_cfg_reg <= wr_data;
                default: ;
            endcase
        end
    end

    // ****************************************
    // Readback
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data <= 8'h00;
        end else if (ce && rd_en) begin
            unique case (rd_addr)
                ADDR_P1_SEL: rd_data <= p1_sel_reg;
                ADDR_P2_SEL: rd_data <= p2_sel_reg;
                ADDR_P3_DIV_LO: rd_data <= p3_div_lo_reg;
                ADDR_P3_DIV_HI: rd_data <= p3_div_hi_reg;
                ADDR_P3_PLL: rd_data <= p3_pll_reg;
                ADDR_P3_SEL: rd_data <= p3_sel_reg;
                ADDR_P3_DS: rd_data <= {p3_ds_reg, 6'h00};
                ADDR_D1_SRC: rd_data <= d1_src_reg;
                ADDR_D1_DS: rd_data <= {D1_DS_FIXED_HI, d1_ds_reg, 4'h0};
                ADDR_D2_CFG: rd_data <= d2_cfg_reg;
                default: rd_data <= 8'h00;
            endcase
        end
    end

    // ****************************************
    // PLL power and lock tracking
    // ****************************************
    assign p3_restart = ce && wr_en && (wr_addr == ADDR_P3_DIV_LO || wr_addr == ADDR_P3_DIV_HI
                        || wr_addr == ADDR_P3_PLL);

    cocr_lock_timer #(
        .LOCK_CYC(LOCK_CYC)
    ) u_lock (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .pll_on(p3_pll_power),
        .restart(p3_restart),
        .locked(p3_lock_raw)
    );

    logic [2:0] d1_sel;
    logic [2:0] d2_sel;
    logic [2:0] d1_dec;
    logic [2:0] d2_dec;
    assign d1_dec = src_decode(d1_src_reg[5:0]);
    assign d2_dec = src_decode(d2_cfg_reg[5:0]);
    assign d1_sel = d1_dec;
    assign d2_sel = d2_dec;

    // ****************************************
    // Output control
    // ****************************************
    always_comb begin
        p3_pll_power = (p3_pll_reg != RST_P3_PLL);
        p3_pll_locked = p3_lock_raw;
        p3_divider = {p3_div_hi_reg, p3_div_lo_reg};
        p3_pll_config = p3_pll_reg;
        p3_freq_select = p3_sel_reg[7:2];
        // Buffer enable from select bits 7:2, gated by the PLL lock; off until locked
        primary_out_three_enable = (p3_sel_reg[7:2] != P3_SEL_OFF) && p3_lock_raw;
        p1_drive_strength_field = p1_sel_reg[DS_LSB_P1 +: 2];
        p2_drive_strength_field = p3_sel_reg[1:0];
        p3_drive_strength_field = p3_ds_reg;
        d1_drive_strength_field = d1_ds_reg;
        d2_drive_strength_field = d2_cfg_reg[DS_LSB_D2 +: 2];
        duplicate_out_one_enable = (d1_sel != 3'h0);
        duplicate_out_two_enable = (d2_sel != 3'h0);
        duplicate_out_one_source = 2'(d1_sel - 3'h1);
        duplicate_out_two_source = 2'(d2_sel - 3'h1);
        if (d1_sel == 3'h4) begin
            duplicate_out_one_source = 2'h3;
            duplicate_out_one_enable = p3_lock_raw;
        end
        if (d2_sel == 3'h4) begin
            duplicate_out_two_source = 2'h3;
            duplicate_out_two_enable = p3_lock_raw;
        end
    end
endmodule
`default_nettype wire

// File: cocr_regs_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Port checks
// ****
module cocr_regs_chk #(
    parameter int LOCK_CYC = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic rd_en,
    input wire logic [7:0] rd_addr,
    input wire logic [7:0] rd_data,
    input wire logic [1:0] p2_drive_strength_field,
    input wire logic [1:0] p3_drive_strength_field,
    input wire logic [1:0] d1_drive_strength_field,
    input wire logic p3_pll_power,
    input wire logic p3_pll_locked,
    input wire logic primary_out_three_enable,
    input wire logic duplicate_out_one_enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_w(logic [7:0] a);
        ce && wr_en && wr_addr == a;
    endsequence
    sequence s_r(logic [7:0] a);
        ce && rd_en && rd_addr == a;
    endsequence
    AST_D1_ON: assert property (s_w(8'h55) ##0 (wr_data[5:0] == 6'h18) |=> duplicate_out_one_enable)
        else $error("first duplicate not on after ref code");
    AST_D1_OFF: assert property (s_w(8'h55) ##0 (wr_data[5:0] == 6'h0C) |=> !duplicate_out_one_enable)
        else $error("first duplicate not off after off code");
    AST_P2_DS: assert property (s_w(8'h53) |=> p2_drive_strength_field == $past(wr_data[1:0]))
        else $error("second output strength wrong");
    AST_P3_DS: assert property (s_w(8'h54) |=> p3_drive_strength_field == $past(wr_data[7:6]))
        else $error("third output strength wrong");
    AST_D1_DS: assert property (s_w(8'h56) |=> d1_drive_strength_field == $past(wr_data[5:4]))
        else $error("first duplicate strength wrong");
    AST_FIX56: assert property (s_r(8'h56) |=> rd_data[7:6] == 2'h3 && rd_data[3:0] == 4'h0)
        else $error("fixed bits of first duplicate strength byte wrong");
    AST_FIX54: assert property (s_r(8'h54) |=> rd_data[5:0] == 6'h00)
        else $error("fixed bits of third output strength byte wrong");
    AST_RELOCK: assert property (s_w(8'h15) |=> !p3_pll_locked)
        else $error("lock kept across pll write");
    AST_OUT3_LOCK: assert property (primary_out_three_enable |-> p3_pll_locked)
        else $error("third output on without lock");
    AST_PLL_DOWN: assert property (s_w(8'h15) ##0 (wr_data == 8'h00) |=> !p3_pll_power && !p3_pll_locked)
        else $error("pll not powered down");
endmodule

bind cocr_regs cocr_regs_chk #(.LOCK_CYC(LOCK_CYC)) chk_u (.clk, .rst, .ce, .wr_en, .wr_addr, .wr_data, .rd_en,
    .rd_addr, .rd_data, .p2_drive_strength_field, .p3_drive_strength_field, .d1_drive_strength_field,
    .p3_pll_power, .p3_pll_locked, .primary_out_three_enable, .duplicate_out_one_enable);
`default_nettype wire

// File: tb_clock_output_config_regs.sv
`timescale 1ns/10ps
`default_nettype none
module tb_clock_output_config_regs;
    import cocr_pkg::*;
    logic clk = 0, rst = 1, ce = 1, wr_en, rd_en, pw, lk, e3, e1, e2;
    logic [7:0] wa, wd, ra, rdd, v;
    logic [1:0] ds1, ds2, ds3, dd1, dd2, s1, s2;
    logic [15:0] dv;
    logic [7:0] pc;
    logic [5:0] fs;
    int n_mismatch = 0, n_checks = 0, cyc = 0;
    logic [23:0] tbl [10] = '{24'h48C9C9, 24'h508A8A, 24'h532E2E, 24'h54FFC0, 24'h56FFF0, 24'h5600C0,
        24'h55CBCB, 24'h579898, 24'h152424, 24'h605A00};
    logic [15:0] cv [4] = '{16'hC903, 16'h8A05, 16'hD801, 16'h0B07};
    logic [15:0] rt [7] = '{16'h533E, 16'h550C, 16'h5798, 16'h1500, 16'h5480, 16'h56E0, 16'h488D};
    cocr_regs #(.LOCK_CYC(4)) dut_u (.clk(clk), .rst(rst), .ce(ce), .wr_en(wr_en), .wr_addr(wa), .wr_data(wd),
        .rd_en(rd_en), .rd_addr(ra), .rd_data(rdd), .p1_drive_strength_field(ds1), .p2_drive_strength_field(ds2),
        .p3_drive_strength_field(ds3), .d1_drive_strength_field(dd1), .d2_drive_strength_field(dd2),
        .p3_divider(dv), .p3_pll_config(pc), .p3_freq_select(fs), .p3_pll_power(pw), .p3_pll_locked(lk),
        .primary_out_three_enable(e3), .duplicate_out_one_source(s1), .duplicate_out_one_enable(e1),
        .duplicate_out_two_source(s2), .duplicate_out_two_enable(e2));
    cocr_host host_u (.clk(clk), .rd_data(rdd), .wr_en(wr_en), .wr_addr(wa), .wr_data(wd), .rd_en(rd_en),
        .rd_addr(ra));
    initial forever #10 clk = ~clk;
    task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
        n_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic wl;
        for (int i = 0; i < 40 && lk !== 1'b1; i++) @(negedge clk);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            test_done;
        end
    end
    // ****
    // Sequence
    // ****
    initial begin
        repeat (5) @(negedge clk);
        rst = 0;
        foreach (tbl[i]) begin
            host_u.wr(tbl[i][23:16], tbl[i][15:8]);
            host_u.rd(tbl[i][23:16], v);
            chk("row", v, tbl[i][7:0]);
        end
        chk("ds12", {4'h0, ds1, ds2}, 8'h0E);
        host_u.wr(8'h14, 8'h06);
        chk("lk", {7'h0, lk}, 8'h00);
        chk("dvh", dv[15:8], 8'h06);
        chk("dvl", dv[7:0], 8'h00);
        chk("pc", pc, 8'h24);
        chk("fs", {2'h0, fs}, 8'h0B);
        wl;
        chk("on3", {6'h0, lk, e3}, 8'h03);
        host_u.wr(8'h53, 8'h3E);
        chk("off3", {6'h0, lk, e3}, 8'h02);
        host_u.wr(8'h53, 8'h2E);
        chk("re3", {6'h0, lk, e3}, 8'h03);
        host_u.cp_d1_p3(8'h2E);
        chk("d1p3", {5'h0, s1, e1}, 8'h07);
        host_u.cp_d2(2'h1, 6'h0B);
        chk("d2p3", {3'h0, dd2, s2, e2}, 8'h0F);
        host_u.wr(8'h15, 8'h00);
        chk("pd", {5'h0, pw, lk, e3}, 8'h00);
        host_u.wr(8'h15, 8'h24);
        chk("pu", {5'h0, pw, lk, e3}, 8'h04);
        wl;
        chk("lk2", {7'h0, lk}, 8'h01);
        foreach (cv[i]) begin
            host_u.cp_d1(cv[i][15:8]);
            chk("d1", {5'h0, s1, e1}, cv[i][7:0]);
        end
        host_u.wr(8'h55, 8'hCC);
        chk("d1off", {7'h0, e1}, 8'h00);
        host_u.wr(8'h57, 8'h8C);
        chk("d2off", {7'h0, e2}, 8'h00);
        ce = 0;
        host_u.wr(8'h54, 8'h00);
        ce = 1;
        chk("ce", {6'h0, ds3}, 8'h03);
        for (int c = 0; c < 4; c++) begin
            host_u.wr(8'h54, {c[1:0], 6'h00});
            chk("ds", {6'h0, ds3}, {6'h0, c[1:0]});
        end
        rst = 1;
        @(negedge clk);
        chk("rst", {e3, e2, e1, pw, dd2, 2'h0}, 8'h48);
        chk("dsr", {ds1, ds2, ds3, dd1}, 8'hAA);
        chk("rdr", rdd, 8'h00);
        rst = 0;
        foreach (rt[i]) begin
            host_u.rd(rt[i][15:8], v);
            chk("def", v, rt[i][7:0]);
        end
        test_done;
    end
endmodule
`default_nettype wire
